/* hdl/boot_loader_pkg.sv */
// Constants shared by the boot-mode reset loader and its testbench.
package boot_loader_pkg;

	// ****************************************
	// Addressing
	// ****************************************
	localparam logic [7:0]  RUN_DEV_ADDR     = 8'hB2;
	localparam logic [7:0]  BOOT_DEV_ADDR    = 8'h88;
	localparam logic [7:0]  AUDIO_SPACE      = 8'h00;
	localparam int          SPACE_MSB        = 23;
	localparam int          SPACE_LSB        = 16;
	localparam int          OFFSET_MSB       = 15;
	localparam logic [3:0]  WRITE_FRAME_LEN  = 4'h7;
	localparam logic [3:0]  READ_FRAME_LEN   = 4'h8;

	// ****************************************
	// Boot modes and sequencing
	// ****************************************
	typedef enum logic [1:0] {
		BOOT_I2C_SLAVE  = 2'b00,
		BOOT_I2C_EEPROM = 2'b01,
		BOOT_ROM_ONLY   = 2'b10,
		BOOT_SPI_SLAVE  = 2'b11
	} boot_mode_t;

	typedef enum logic [1:0] {
		ST_HOLD  = 2'b00,
		ST_STRAP = 2'b01,
		ST_BOOT  = 2'b10,
		ST_RUN   = 2'b11
	} boot_state_t;

	localparam logic [1:0]  CFG_RESET        = 2'h0;
	localparam logic [3:0]  SPI_BITS         = 4'h8;
	localparam int          SYNC_CNT_W       = 16;

endpackage : boot_loader_pkg

/* hdl/boot_byte_buffer.sv */
// Two-entry valid/ready buffer for boot data bytes.
`timescale 1ns/1ps
module boot_byte_buffer #(
	parameter int W = 8
) (
	input  wire logic         core_clk,
	input  wire logic         reset,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);

	logic [W-1:0] spare_r;
	logic         spare_ok_r;
	logic         head_ok_r;
	logic [W-1:0] head_r;
	wire          take_in  = in_valid && in_ready;
	wire          take_out = head_ok_r && out_ready;

	// ****************************************
	// Storage
	// ****************************************
	// The spare slot holds a word while the head is stalled, so ready may be a flop.
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			head_r     <= '0;
			head_ok_r  <= 1'b0;
			spare_r    <= '0;
			spare_ok_r <= 1'b0;
		end
		else
		begin
			if (!head_ok_r || take_out)
			begin
				head_ok_r <= spare_ok_r || take_in;
				head_r    <= spare_ok_r ? spare_r : in_data;
				spare_ok_r <= spare_ok_r && take_in;
				if (spare_ok_r)
					spare_r <= in_data;
			end
			else if (take_in)
			begin
				spare_ok_r <= 1'b1;
				spare_r    <= in_data;
			end
		end
	end

	assign in_ready  = !spare_ok_r;
	assign out_valid = head_ok_r;
	assign out_data  = head_r;

endmodule : boot_byte_buffer

/* hdl/boot_mode_reset_loader.sv */
// Reset, boot-mode strap capture, shared pin handover and register decode.
//
// Operation
// (RULE1) At run time respond to register transactions at control address 0xB2.
// (RULE2) Address byte 23:16 selects the space, bits 15:0 the location.
// (RULE3) Audio settings live in the space whose selector byte is zero.
// (RULE4) While booting, the four shared serial pins form an SPI input port; the code uses three, in SPI slave boot only.
// (RULE5) After boot the serial pins are released to amplifier I/O.
// (RULE6) Low external reset holds the block; initialisation starts on release.
// (RULE7) Any brownout trip drives the brownout reset output low.
// (RULE8) On reset release latch both boot strap pins and start that boot.
// (RULE9) Strap pair, high first: 00 I2C slave, 01 EEPROM, 10 ROM, 11 SPI.
// (RULE10) Boot mode zero answers as I2C slave at address 0x88.
// (RULE11) Boot mode one makes the device bus master reading an EEPROM.
// (RULE12) Boot mode three takes boot code as an SPI slave.
// (RULE13) A controller keeps off the bus while the EEPROM loads.
// (RULE14) Sync pin is a config input in reset, the sync output when running.
// (RULE15) Sync output follows the programmed period and high time.
// (RULE16) With an EEPROM present, save parameters and recall them at boot.
// (RULE17) Parameter writes are accepted once the device is running.
// (RULE18) Both shared config pin levels are latched on reset exit.
// (RULE19) A transaction is address byte, three address and three data bytes.
// (RULE20) One boot-complete flag switches every shared pin in the same cycle; amp_pin_levels and the sync output level lag it by one cycle.
`timescale 1ns/1ps
module boot_mode_reset_loader #(
	parameter int SYNC_W = boot_loader_pkg::SYNC_CNT_W
) (
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              external_reset_low,
	input  wire logic [2:0]        brownout_trip,
	output logic                   brownout_reset_out_n,
	input  wire logic              boot_select_low_pin,
	input  wire logic              boot_select_high_pin,
	input  wire logic              supply_sync_cfg_high_in,
	output logic                   supply_sync_cfg_high_out,
	output logic                   supply_sync_cfg_high_oe,
	input  wire logic              fault_cfg_low_in,
	output logic                   fault_cfg_low_out,
	output logic                   fault_cfg_low_oe,
	input  wire logic              fault_active,
	input  wire logic              tref_serial_clock,
	input  wire logic              tsense_serial_in,
	input  wire logic              vol_lo_serial_select,
	input  wire logic              vol_hi_serial_out_in,
	output logic                   vol_hi_serial_out_out,
	output logic                   vol_hi_serial_out_oe,
	output logic [3:0]             amp_pin_levels,
	output logic [1:0]             boot_mode,
	output logic [1:0]             cfg_mode,
	output logic                   boot_complete,
	output logic                   i2c_master_enable,
	output logic                   eeprom_recall,
	input  wire logic              eeprom_present,
	input  wire logic              eeprom_save_req,
	output logic                   eeprom_save,
	output logic [7:0]             slave_dev_addr,
	input  wire logic              boot_done,
	input  wire logic              ext_byte_valid,
	input  wire logic [7:0]        ext_byte_data,
	output logic                   ext_byte_ready,
	output logic                   spi_overrun,
	output logic                   boot_byte_valid,
	output logic [7:0]             boot_byte_data,
	input  wire logic              boot_byte_ready,
	input  wire logic              txn_valid,
	input  wire logic [7:0]        txn_dev_addr,
	input  wire logic [3:0]        txn_byte_count,
	input  wire logic [23:0]       txn_addr,
	input  wire logic [23:0]       txn_data,
	output logic                   reg_wr,
	output logic                   reg_rd,
	output logic [7:0]             reg_space,
	output logic [15:0]            reg_offset,
	output logic [23:0]            reg_wdata,
	output logic                   audio_sel,
	input  wire logic [SYNC_W-1:0] sync_period,
	input  wire logic [SYNC_W-1:0] sync_high
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Bit order: 0 reset, 1-3 brownout, 4-5 strap, 6-7 cfg, 8 sck, 9 mosi, 10 select, 11 miso pin.
	localparam int NS = 12;
	logic [NS-1:0] meta_r;
	logic [NS-1:0] sync_r;
	logic          sck_d_r;
	wire  [NS-1:0] pins_raw = {vol_hi_serial_out_in, vol_lo_serial_select, tsense_serial_in, tref_serial_clock,
	                           fault_cfg_low_in, supply_sync_cfg_high_in, boot_select_high_pin,
	                           boot_select_low_pin, brownout_trip, external_reset_low};

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			meta_r  <= '0;
			sync_r  <= '0;
			sck_d_r <= 1'b0;
		end
		else
		begin
			meta_r  <= pins_raw;
			sync_r  <= meta_r;
			sck_d_r <= sync_r[8];
		end
	end

	wire       ext_high  = sync_r[0];
	wire       bo_any    = |sync_r[3:1];
	wire [1:0] strap_now = {sync_r[5], sync_r[4]};
	wire [1:0] cfg_now   = {sync_r[6], sync_r[7]};
	wire       sck_rise  = sync_r[8] && !sck_d_r;

	// ****************************************
	// Boot sequencer
	// ****************************************
	boot_loader_pkg::boot_state_t state_r;
	boot_loader_pkg::boot_state_t state_nxt;
	logic [1:0] mode_r;
	logic [1:0] cfg_r;
	logic       bo_n_r;

	wire running   = (state_r == boot_loader_pkg::ST_RUN);
	wire booting   = (state_r == boot_loader_pkg::ST_BOOT);
	wire mode_spi  = (mode_r == boot_loader_pkg::BOOT_SPI_SLAVE); // RULE12
	wire mode_eep  = (mode_r == boot_loader_pkg::BOOT_I2C_EEPROM); // RULE11
	wire mode_i2cs = (mode_r == boot_loader_pkg::BOOT_I2C_SLAVE); // RULE10
	wire drained   = !boot_byte_valid && buf_ready && !spi_push_r;

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			boot_loader_pkg::ST_HOLD:  if (ext_high) state_nxt = boot_loader_pkg::ST_STRAP; // RULE6
			boot_loader_pkg::ST_STRAP: state_nxt = boot_loader_pkg::ST_BOOT; // RULE8
			boot_loader_pkg::ST_BOOT:  if (boot_done && drained) state_nxt = boot_loader_pkg::ST_RUN; // RULE20
			boot_loader_pkg::ST_RUN:   state_nxt = boot_loader_pkg::ST_RUN;
		endcase
		if (!ext_high)
			state_nxt = boot_loader_pkg::ST_HOLD; // RULE6
	end

	// The straps are caught by a clocked process after release, never by the reset itself.
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			state_r <= boot_loader_pkg::ST_HOLD;
			mode_r  <= 2'h0;
			cfg_r   <= boot_loader_pkg::CFG_RESET;
			bo_n_r  <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			bo_n_r  <= !bo_any; // RULE7
			if (state_r == boot_loader_pkg::ST_STRAP)
			begin
				mode_r <= strap_now; // RULE8 RULE9
				cfg_r  <= cfg_now; // RULE18
			end
		end
	end

	// ****************************************
	// SPI boot port
	// ****************************************
	logic [7:0] spi_sh_r;
	logic [3:0] spi_cnt_r;
	logic       spi_push_r;
	logic       ovr_r;
	wire        spi_active = booting && mode_spi && !sync_r[10]; // RULE4 RULE5
	wire        spi_byte   = spi_active && sck_rise && (spi_cnt_r == boot_loader_pkg::SPI_BITS - 4'h1);
	wire        buf_ready;
	wire        buf_in_v   = mode_spi ? spi_push_r : (booting && ext_byte_valid);
	wire [7:0]  buf_in_d   = mode_spi ? spi_sh_r : ext_byte_data;

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			spi_sh_r   <= 8'h00;
			spi_cnt_r  <= 4'h0;
			spi_push_r <= 1'b0;
			ovr_r      <= 1'b0;
		end
		else
		begin
			spi_push_r <= spi_byte;
			if (!spi_active)
				spi_cnt_r <= 4'h0;
			else if (sck_rise)
			begin
				spi_sh_r  <= {spi_sh_r[6:0], sync_r[9]}; // RULE12
				spi_cnt_r <= spi_byte ? 4'h0 : spi_cnt_r + 4'h1;
			end
			// An SPI master cannot be stalled, so a byte meeting a full buffer is flagged.
			if (mode_spi && spi_push_r && !buf_ready)
				ovr_r <= 1'b1;
			else if (state_r == boot_loader_pkg::ST_STRAP)
				ovr_r <= 1'b0;
		end
	end

	boot_byte_buffer #(
		.W (8)
	) u_buf (
		.core_clk  (core_clk),
		.reset     (reset),
		.in_valid  (buf_in_v),
		.in_data   (buf_in_d),
		.in_ready  (buf_ready),
		.out_valid (boot_byte_valid),
		.out_data  (boot_byte_data),
		.out_ready (boot_byte_ready)
	);

	// ****************************************
	// Register transaction decode
	// ****************************************
	logic        wr_r;
	logic        rd_r;
	logic [7:0]  space_r;
	logic [15:0] offs_r;
	logic [23:0] wdata_r;
	logic        audio_r;
	logic        save_r;
	logic        recall_r;
	logic [7:0]  dev_addr_r;

	wire [7:0] dev_match = (running ? boot_loader_pkg::RUN_DEV_ADDR : boot_loader_pkg::BOOT_DEV_ADDR); // RULE1 RULE10
	wire       addr_hit  = (txn_dev_addr[7:1] == dev_match[7:1]);
	wire       port_open = running || (booting && mode_i2cs); // RULE17
	wire       is_write  = txn_byte_count == boot_loader_pkg::WRITE_FRAME_LEN; // RULE19
	wire       is_read   = txn_byte_count == boot_loader_pkg::READ_FRAME_LEN; // RULE19
	wire       txn_ok    = txn_valid && addr_hit && port_open;

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			wr_r       <= 1'b0;
			rd_r       <= 1'b0;
			space_r    <= 8'h00;
			offs_r     <= 16'h0000;
			wdata_r    <= 24'h00_0000;
			audio_r    <= 1'b0;
			save_r     <= 1'b0;
			recall_r   <= 1'b0;
			dev_addr_r <= boot_loader_pkg::BOOT_DEV_ADDR;
		end
		else
		begin
			wr_r       <= txn_ok && is_write;
			rd_r       <= txn_ok && is_read;
			dev_addr_r <= dev_match;
			if (txn_ok && (is_write || is_read))
			begin
				space_r <= txn_addr[boot_loader_pkg::SPACE_MSB:boot_loader_pkg::SPACE_LSB]; // RULE2
				offs_r  <= txn_addr[boot_loader_pkg::OFFSET_MSB:0]; // RULE2
				wdata_r <= txn_data;
				audio_r <= txn_addr[boot_loader_pkg::SPACE_MSB:boot_loader_pkg::SPACE_LSB]
				           == boot_loader_pkg::AUDIO_SPACE; // RULE3
			end
			save_r   <= running && eeprom_present && eeprom_save_req; // RULE16
			recall_r <= booting && mode_eep && eeprom_present; // RULE16 RULE11
		end
	end

	// ****************************************
	// Supply sync and shared pins
	// ****************************************
	logic [SYNC_W-1:0] sync_cnt_r;
	logic              sync_out_r;
	logic              run_r;
	logic              fault_oe_r;
	logic [3:0]        amp_r;

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			sync_cnt_r <= '0;
			sync_out_r <= 1'b0;
			run_r      <= 1'b0;
			amp_r      <= 4'h0;
			fault_oe_r <= 1'b0;
		end
		else
		begin
			run_r <= state_nxt == boot_loader_pkg::ST_RUN; // RULE20
			if (!running || sync_cnt_r >= sync_period)
				sync_cnt_r <= '0;
			else
				sync_cnt_r <= sync_cnt_r + SYNC_W'(1);
			sync_out_r <= running && (sync_cnt_r < sync_high); // RULE15
			amp_r      <= running ? sync_r[11:8] : 4'h0; // RULE5
			fault_oe_r <= (state_nxt == boot_loader_pkg::ST_RUN) && fault_active; // RULE20
		end
	end

	assign brownout_reset_out_n     = bo_n_r;
	assign supply_sync_cfg_high_out = sync_out_r;
	assign supply_sync_cfg_high_oe  = run_r; // RULE14
	assign fault_cfg_low_out        = 1'b0;
	assign fault_cfg_low_oe         = fault_oe_r; // RULE20
	assign vol_hi_serial_out_out    = 1'b0;
	assign vol_hi_serial_out_oe     = 1'b0;
	assign amp_pin_levels           = amp_r;
	assign boot_mode                = mode_r;
	assign cfg_mode                 = cfg_r;
	assign boot_complete            = run_r;
	assign i2c_master_enable        = recall_r;
	assign eeprom_recall            = recall_r;
	assign eeprom_save              = save_r;
	assign slave_dev_addr           = dev_addr_r;
	assign ext_byte_ready           = buf_ready && booting && !mode_spi;
	assign spi_overrun              = ovr_r;
	assign reg_wr                   = wr_r;
	assign reg_rd                   = rd_r;
	assign reg_space                = space_r;
	assign reg_offset               = offs_r;
	assign reg_wdata                = wdata_r;
	assign audio_sel                = audio_r;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	chk_cfg_latch: assert property (state_r == boot_loader_pkg::ST_STRAP |=> cfg_r == $past(cfg_now)) // RULE18
		else $error("config pins not latched on reset exit");
	chk_mode_latch: assert property (state_r == boot_loader_pkg::ST_STRAP |=> boot_mode == $past(strap_now)) // RULE8
		else $error("boot strap not latched");
	chk_hold_reset: assert property (!ext_high |=> state_r == boot_loader_pkg::ST_HOLD) // RULE6
		else $error("left hold while reset low");
	chk_brownout_out: assert property (bo_any |=> !brownout_reset_out_n) // RULE7
		else $error("brownout reset not driven");
	chk_spi_release: assert property (running |-> !spi_active && !spi_push_r ##1 !spi_push_r) // RULE5
		else $error("SPI still active at run");
	chk_sync_oe: assert property ($rose(boot_complete) |-> supply_sync_cfg_high_oe && !$past(running, 2)) // RULE14
		else $error("sync pin handover wrong");
	chk_run_write: assert property (running && txn_valid && txn_dev_addr[7:1] == 7'h59 && is_write |=> reg_wr) // RULE1
		else $error("run write not accepted");
	chk_audio_space: assert property (reg_wr |-> audio_sel == (reg_space == 8'h00)) // RULE3
		else $error("audio space decode wrong");
	chk_boot_addr: assert property (booting |=> slave_dev_addr == 8'h88) // RULE10
		else $error("boot slave address wrong");
	chk_eeprom_master: assert property (booting && mode_eep && eeprom_present |=> i2c_master_enable) // RULE11
		else $error("EEPROM master not enabled");

	cov_spi_boot: cover property (booting && mode_spi ##[1:100] spi_push_r);
	cov_run_write: cover property (running ##1 reg_wr);
	cov_brownout: cover property (running ##1 !brownout_reset_out_n);

endmodule : boot_mode_reset_loader

/* verification/boot_host_model.sv */
// Behavioural boot host: byte source toward the loader and a stalling sink behind its buffer.
`timescale 1ns/1ps
module boot_host_model (
	input  wire logic       core_clk,
	input  wire logic       slow,
	output logic            ext_byte_valid,
	output logic [7:0]      ext_byte_data,
	input  wire logic       ext_byte_ready,
	input  wire logic       boot_byte_valid,
	input  wire logic [7:0] boot_byte_data,
	output logic            boot_byte_ready
);
	// ****************************************
	// Source and sink
	// ****************************************
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	logic       took = 1'b0;
	logic [1:0] beat = 2'h0;

	initial
	begin
		ext_byte_valid  = 1'b0;
		ext_byte_data   = 8'h00;
		boot_byte_ready = 1'b0;
	end

	// A byte counts as taken only at the rising edge that sees ready high.
	always @(posedge core_clk)
	begin
		took = ext_byte_valid && ext_byte_ready;
		if (boot_byte_valid && boot_byte_ready)
			rx_q.push_back(boot_byte_data);
	end

	// An idle data line keeps changing, so a stale byte can never pass for a fresh one.
	always @(negedge core_clk)
	begin
		if (!ext_byte_valid || took)
		begin
			ext_byte_valid = (tx_q.size() != 0);
			ext_byte_data  = ext_byte_valid ? tx_q.pop_front() : ~ext_byte_data;
		end
		beat            = beat + 2'h1;
		boot_byte_ready = !slow || (beat == 2'h0);
	end
endmodule : boot_host_model

/* verification/test_boot_mode_reset_loader.sv */
// Self-checking bench for the boot-mode reset loader.
`timescale 1ns/1ps
module test_boot_mode_reset_loader;
	// ****************************************
	// Signals and checks
	// ****************************************
	localparam int LIMIT = 20000;
	logic        core_clk = 1'b0, reset = 1'b1, external_reset_low = 1'b0, boot_select_low_pin = 1'b0;
	logic        boot_select_high_pin = 1'b0, supply_sync_cfg_high_in = 1'b0, fault_cfg_low_in = 1'b0;
	logic        fault_active = 1'b0, tref_serial_clock = 1'b0, tsense_serial_in = 1'b0;
	logic        vol_lo_serial_select = 1'b1, vol_hi_serial_out_in = 1'b0, eeprom_present = 1'b0;
	logic        eeprom_save_req = 1'b0, boot_done = 1'b0, txn_valid = 1'b0, slow = 1'b0;
	logic [2:0]  brownout_trip = 3'h0;
	logic [7:0]  txn_dev_addr = 8'h00;
	logic [3:0]  txn_byte_count = 4'h0;
	logic [23:0] txn_addr = 24'h00_0000, txn_data = 24'h00_0000;
	logic [15:0] sync_period = 16'h0009, sync_high = 16'h0003;
	logic        brownout_reset_out_n, supply_sync_cfg_high_out, supply_sync_cfg_high_oe, fault_cfg_low_out;
	logic        fault_cfg_low_oe, vol_hi_serial_out_out, vol_hi_serial_out_oe, boot_complete, i2c_master_enable;
	logic        eeprom_recall, eeprom_save, ext_byte_valid, ext_byte_ready, spi_overrun, boot_byte_valid;
	logic        boot_byte_ready, reg_wr, reg_rd, audio_sel;
	logic [3:0]  amp_pin_levels;
	logic [1:0]  boot_mode, cfg_mode;
	logic [7:0]  slave_dev_addr, ext_byte_data, boot_byte_data, reg_space;
	logic [15:0] reg_offset;
	logic [23:0] reg_wdata;
	logic [31:0] seed = 32'h0000_0113;
	int          failures = 0, comparisons = 0, cycles = 0, refusals = 0;

	boot_mode_reset_loader DUT (
		.core_clk, .reset, .external_reset_low, .brownout_trip, .brownout_reset_out_n, .boot_select_low_pin,
		.boot_select_high_pin, .supply_sync_cfg_high_in, .supply_sync_cfg_high_out, .supply_sync_cfg_high_oe,
		.fault_cfg_low_in, .fault_cfg_low_out, .fault_cfg_low_oe, .fault_active, .tref_serial_clock,
		.tsense_serial_in, .vol_lo_serial_select, .vol_hi_serial_out_in, .vol_hi_serial_out_out,
		.vol_hi_serial_out_oe, .amp_pin_levels, .boot_mode, .cfg_mode, .boot_complete, .i2c_master_enable,
		.eeprom_recall, .eeprom_present, .eeprom_save_req, .eeprom_save, .slave_dev_addr, .boot_done,
		.ext_byte_valid, .ext_byte_data, .ext_byte_ready, .spi_overrun, .boot_byte_valid, .boot_byte_data,
		.boot_byte_ready, .txn_valid, .txn_dev_addr, .txn_byte_count, .txn_addr, .txn_data, .reg_wr, .reg_rd,
		.reg_space, .reg_offset, .reg_wdata, .audio_sel, .sync_period, .sync_high
	);

	boot_host_model host (
		.core_clk, .slow, .ext_byte_valid, .ext_byte_data, .ext_byte_ready, .boot_byte_valid, .boot_byte_data,
		.boot_byte_ready
	);

	always #2 core_clk = ~core_clk;

	always @(posedge core_clk)
	begin
		cycles = cycles + 1;
		if (ext_byte_valid && !ext_byte_ready)
			refusals = refusals + 1;
		if (cycles == LIMIT)
		begin
			failures = failures + 1;
			close_out();
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// Only the upper seven address bits identify the device; bit zero is the direction.
	function automatic logic [1:0] txn_expect(input logic [7:0] dev, input logic [3:0] cnt, input logic run,
		input logic [1:0] m);
		logic ok;
		ok = run ? (dev[7:1] == boot_loader_pkg::RUN_DEV_ADDR[7:1])
			: (m == boot_loader_pkg::BOOT_I2C_SLAVE && dev[7:1] == boot_loader_pkg::BOOT_DEV_ADDR[7:1]);
		return {ok && cnt == boot_loader_pkg::WRITE_FRAME_LEN, ok && cnt == boot_loader_pkg::READ_FRAME_LEN};
	endfunction : txn_expect

	task automatic check_val(input string what, input logic [23:0] exp, input logic [23:0] got);
		comparisons = comparisons + 1;
		if (got !== exp)
		begin
			failures = failures + 1;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check_val

	task automatic close_out();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic txn(input logic [7:0] dev, input logic [3:0] cnt, input logic [23:0] a, input logic run,
		input logic [1:0] m);
		logic [1:0]  e;
		logic [31:0] r;
		e              = txn_expect(dev, cnt, run, m);
		r              = rnd();
		txn_valid      = 1'b1;
		txn_dev_addr   = dev;
		txn_byte_count = cnt;
		txn_addr       = a;
		txn_data       = r[23:0];
		@(negedge core_clk);
		txn_valid = 1'b0;
		check_val("reg_wr", e[1], reg_wr);
		check_val("reg_rd", e[0], reg_rd);
		if (e != 2'b00)
		begin
			check_val("reg_space", a[23:16], reg_space);
			check_val("reg_offset", a[15:0], reg_offset);
			check_val("audio_sel", a[23:16] == boot_loader_pkg::AUDIO_SPACE, audio_sel);
		end
		if (e[1])
			check_val("reg_wdata", r[23:0], reg_wdata);
		@(negedge core_clk);
		check_val("reg_pulse", 2'b00, {reg_wr, reg_rd});
	endtask : txn

	task automatic rand_txn(input logic run, input logic [1:0] m);
		logic [31:0] r;
		r = rnd();
		txn(r[2] ? r[31:24] : ((r[1] ? boot_loader_pkg::BOOT_DEV_ADDR : boot_loader_pkg::RUN_DEV_ADDR) | {7'h00, r[0]}),
			r[4] ? r[12:9] : (r[3] ? boot_loader_pkg::READ_FRAME_LEN : boot_loader_pkg::WRITE_FRAME_LEN),
			r[5] ? {8'h00, r[28:13]} : r[29:6], run, m);
	endtask : rand_txn

	// The serial clock stays low between frames and each level is held three cycles for the synchroniser.
	task automatic spi_byte(input logic [7:0] b);
		vol_lo_serial_select = 1'b0;
		for (int k = 7; k >= 0; k--)
		begin
			tsense_serial_in  = b[k];
			tref_serial_clock = 1'b0;
			repeat (3) @(negedge core_clk);
			tref_serial_clock = 1'b1;
			repeat (3) @(negedge core_clk);
		end
		tref_serial_clock = 1'b0;
		repeat (6) @(negedge core_clk);
		vol_lo_serial_select = 1'b1;
		tsense_serial_in     = ~b[0];
	endtask : spi_byte

	task automatic boot_run(input logic [1:0] m, input logic ee);
		logic [31:0] r;
		int          i;
		int          n;
		r = rnd();
		boot_done          = 1'b0;
		external_reset_low = 1'b0;
		eeprom_present     = ee;
		eeprom_save_req    = r[2];
		{boot_select_high_pin, boot_select_low_pin} = m;
		{supply_sync_cfg_high_in, fault_cfg_low_in} = r[1:0];
		repeat (5) @(negedge core_clk);
		check_val("held", {1'b0, boot_loader_pkg::BOOT_DEV_ADDR}, {boot_complete, slave_dev_addr});
		external_reset_low = 1'b1;
		repeat (7) @(negedge core_clk);
		// Moving the straps after capture proves that the latched copy is what counts.
		{boot_select_high_pin, boot_select_low_pin} = ~m;
		{supply_sync_cfg_high_in, fault_cfg_low_in} = ~r[1:0];
		repeat (2) @(negedge core_clk);
		check_val("boot_mode", m, boot_mode);
		check_val("cfg_mode", r[1:0], cfg_mode);
		check_val("master_en", m == boot_loader_pkg::BOOT_I2C_EEPROM && ee, i2c_master_enable);
		check_val("recall", m == boot_loader_pkg::BOOT_I2C_EEPROM && ee, eeprom_recall);
		check_val("boot_pins", 8'h00, {boot_complete, supply_sync_cfg_high_oe, amp_pin_levels, vol_hi_serial_out_oe,
			eeprom_save});
		host.rx_q.delete();
		refusals = 0;
		slow     = 1'b1;
		n        = (m == boot_loader_pkg::BOOT_SPI_SLAVE) ? 2 : 5;
		for (i = 0; i < n; i++)
			if (m == boot_loader_pkg::BOOT_SPI_SLAVE)
				spi_byte(r[15:8] ^ i[7:0]);
			else
				host.tx_q.push_back(r[15:8] ^ i[7:0]);
		for (i = 0; i < 400 && host.rx_q.size() < n; i++)
			@(negedge core_clk);
		for (i = 0; i < n; i++)
			check_val("boot_byte", r[15:8] ^ i[7:0], host.rx_q[i]);
		check_val("refused", m != boot_loader_pkg::BOOT_SPI_SLAVE, refusals > 0);
		check_val("overrun", 1'b0, spi_overrun);
		slow = 1'b0;
		// A controller stays off the bus while the EEPROM boot is reading.
		if (m != boot_loader_pkg::BOOT_I2C_EEPROM)
			repeat (6) rand_txn(1'b0, m);
		boot_done = 1'b1;
		for (i = 0; i < 100 && boot_complete !== 1'b1; i++)
			@(negedge core_clk);
		fault_active = r[3];
		r            = rnd();
		{vol_hi_serial_out_in, vol_lo_serial_select, tsense_serial_in, tref_serial_clock} = r[3:0];
		repeat (4) @(negedge core_clk);
		check_val("run_addr", boot_loader_pkg::RUN_DEV_ADDR, slave_dev_addr);
		check_val("run_pins", {4'hC, fault_active, 4'h0, r[3:0]}, {boot_complete, supply_sync_cfg_high_oe,
			i2c_master_enable, eeprom_recall, fault_cfg_low_oe, fault_cfg_low_out, vol_hi_serial_out_oe,
			vol_hi_serial_out_out, vol_lo_serial_select && 1'b0, amp_pin_levels});
		check_val("save", ee && eeprom_save_req, eeprom_save);
		txn(boot_loader_pkg::RUN_DEV_ADDR, boot_loader_pkg::WRITE_FRAME_LEN, {8'h00, r[31:16]}, 1'b1, m);
		txn(boot_loader_pkg::RUN_DEV_ADDR | 8'h01, boot_loader_pkg::READ_FRAME_LEN, r[31:8], 1'b1, m);
		repeat (20) rand_txn(1'b1, m);
		brownout_trip = r[5] ? 3'h4 : (r[4] ? 3'h2 : 3'h1);
		repeat (3) @(negedge core_clk);
		check_val("brownout", 1'b0, brownout_reset_out_n);
		brownout_trip = 3'h0;
		repeat (4) @(negedge core_clk);
		check_val("brownout_off", 1'b1, brownout_reset_out_n);
		n = 0;
		repeat (40)
		begin
			@(negedge core_clk);
			n = n + int'(supply_sync_cfg_high_out);
		end
		check_val("sync_high", 24'(4 * sync_high), 24'(n));
	endtask : boot_run

	initial
	begin
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		reset = 1'b0;
		check_val("reset_state", {boot_loader_pkg::BOOT_DEV_ADDR, 2'b00}, {slave_dev_addr, boot_complete,
			brownout_reset_out_n});
		for (int p = 0; p < 8; p++)
			boot_run(p[1:0], p[2]);
		close_out();
	end
endmodule : test_boot_mode_reset_loader
